// ### rtl/cpps_pkg.sv
// constants, state encoding and register map of the power-path sequencer
// assumes one 200 MHz clock and an APB master that owns the register bus
//
// Overview of operation
// - reset starts with battery connected when present
// - adapter ok, wait 150ms or 1.3s, swap
// - outgoing switch off before incoming on, except failed gate check swaps at one edge
// - no adapter: adapter off, battery on if healthy
// - swap only if not discharging or depleted
// - gate low after 20ms: off, retry 1.3s
// - seventh failure in 90s latches adapter off
// - failure counter clears after 90 seconds
// - charging disabled while adapter switches are off
// - adapter off when not ok or discharge undepleted
// - option bit 6 forces battery discharge mode
// - depleted battery ends discharge, clears bit 6
// - bits 12:11 select depletion threshold
// - charging starts only when every condition holds
// - any fault or inhibit stops charging
// - soft start 128mA, 64mA steps per 240us
// - option bit 5 selects current monitor source
// - watchdog expiry suspends charging, keeps registers
// - voltage or current write restarts watchdog
// - option bits 14:13 select watchdog period
// - disabling watchdog after expiry resumes charging
// - low bootstrap voltage starts low-side refresh, except while charging is disabled
// - option bit 15 picks long delay later
package cpps_pkg;

    // ===========================================================
    // time base
    localparam int          CLK_PERIOD_NS = 5;
    localparam int          TICK_NS       = 1000;
    localparam logic [7:0]  TICK_CYC      = 8'(TICK_NS / CLK_PERIOD_NS);
    localparam int          TICKS_PER_MS  = 1000000 / TICK_NS;

    localparam int          DLY_SHORT_MS  = 150;
    localparam int          DLY_LONG_MS   = 1300;
    localparam int          GATE_CHK_MS   = 20;
    localparam int          RETRY_MS      = 1300;
    localparam int          FAIL_WIN_S    = 90;
    localparam int          WD_44_S       = 44;
    localparam int          WD_88_S       = 88;
    localparam int          WD_175_S      = 175;
    localparam int          SS_STEP_US    = 240;
    localparam int          BBM_US        = 1;

    localparam logic [27:0] DLY_SHORT_TK  = 28'(DLY_SHORT_MS * TICKS_PER_MS);
    localparam logic [27:0] DLY_LONG_TK   = 28'(DLY_LONG_MS * TICKS_PER_MS);
    localparam logic [27:0] GATE_CHK_TK   = 28'(GATE_CHK_MS * TICKS_PER_MS);
    localparam logic [27:0] RETRY_TK      = 28'(RETRY_MS * TICKS_PER_MS);
    localparam logic [27:0] FAIL_WIN_TK   = 28'(FAIL_WIN_S * 1000 * TICKS_PER_MS);
    localparam logic [27:0] WD_44_TK      = 28'(WD_44_S * 1000 * TICKS_PER_MS);
    localparam logic [27:0] WD_88_TK      = 28'(WD_88_S * 1000 * TICKS_PER_MS);
    localparam logic [27:0] WD_175_TK     = 28'(WD_175_S * 1000 * TICKS_PER_MS);
    localparam logic [27:0] SS_STEP_TK    = 28'(SS_STEP_US * TICKS_PER_MS / 1000);
    localparam logic [27:0] BBM_TK        = 28'(BBM_US * TICKS_PER_MS / 1000);

    localparam logic [2:0]  FAIL_MAX      = 3'h7;

    // ===========================================================
    // register map, byte addresses
    localparam logic [7:0]  ADDR_OPTION   = 8'h00;
    localparam logic [7:0]  ADDR_CHG_VOLT = 8'h04;
    localparam logic [7:0]  ADDR_CHG_CURR = 8'h08;
    localparam logic [7:0]  ADDR_IN_CURR  = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS   = 8'h10;

    localparam logic [15:0] OPTION_RST    = 16'h6000;
    localparam logic [15:0] CHG_VOLT_RST  = 16'h0000;
    localparam logic [15:0] CHG_CURR_RST  = 16'h0000;
    localparam logic [15:0] IN_CURR_RST   = 16'h1000;

    // option word fields
    localparam int          OPT_INHIBIT   = 0;
    localparam int          OPT_IMON_SEL  = 5;
    localparam int          OPT_DISCHARGE = 6;
    localparam int          OPT_DEPL_LO   = 11;
    localparam int          OPT_WD_LO     = 13;
    localparam int          OPT_LONG_DLY  = 15;

    // setting word fields
    localparam int          CV_LO         = 4;
    localparam int          CV_HI         = 14;
    localparam int          CC_LO         = 6;
    localparam int          CC_HI         = 12;
    localparam int          IC_LO         = 7;
    localparam int          IC_HI         = 12;

    // soft start in 64 mA units
    localparam logic [6:0]  SS_START      = 7'h02;

    // default watchdog code map: code n selects period n (0 = off)
    localparam logic [7:0]  WD_MAP_DEF    = 8'he4;

    typedef enum logic [2:0] {
        S_BAT, S_DLY, S_BRK_A, S_ADP_ON, S_ADP, S_BRK_B, S_RETRY, S_LATCH
    } cpps_pp_state_t;

    typedef struct packed {
        cpps_pp_state_t st;
        logic [15:0]    opt;
        logic [15:0]    cv;
        logic [15:0]    cc;
        logic [15:0]    ic;
        logic [7:0]     tick_cnt;
        logic           tick;
        logic [27:0]    tmr;
        logic [2:0]     fail_cnt;
        logic [27:0]    win_cnt;
        logic [27:0]    wd_cnt;
        logic           wd_exp;
        logic           long_ok;
        logic           current_limit_input_ok;
        logic [27:0]    ss_cnt;
        logic [6:0]     target;
        logic           adp_drv;
        logic           bat_drv;
        logic           chg_en;
        logic           imon_sel;
        logic           bst_ref;
        logic [1:0]     dep_sel;
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
    } cpps_state_t;

endpackage : cpps_pkg

// ### rtl/cpps_top.sv
// power-path sequencer, charge qualification, soft start and watchdog
// assumes analog comparators deliver clean synchronous levels; presetn
// also covers the adapter-detect-low reset of the device
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module cpps_top
    import cpps_pkg::*;
#(
    parameter logic [27:0] P_DLY_SHORT = DLY_SHORT_TK,
    parameter logic [27:0] P_DLY_LONG  = DLY_LONG_TK,
    parameter logic [27:0] P_GATE_CHK  = GATE_CHK_TK,
    parameter logic [27:0] P_RETRY     = RETRY_TK,
    parameter logic [27:0] P_FAIL_WIN  = FAIL_WIN_TK,
    parameter logic [27:0] P_WD_44     = WD_44_TK,
    parameter logic [27:0] P_WD_88     = WD_88_TK,
    parameter logic [27:0] P_WD_175    = WD_175_TK,
    parameter logic [27:0] P_SS_STEP   = SS_STEP_TK,
    parameter logic [7:0]  P_WD_MAP    = WD_MAP_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        adapter_ok,
    input  wire logic        vcc_above_undervoltage_lockout,
    input  wire logic        battery_sense_above_undervoltage_lockout,
    input  wire logic        adapter_sense_negative_ok,
    input  wire logic        gate_voltage_ok,
    input  wire logic        below_depletion,
    input  wire logic        current_limit_above_start,
    input  wire logic        current_limit_below_stop,
    input  wire logic        battery_overvoltage,
    input  wire logic        thermal_shutdown,
    input  wire logic        input_overcurrent,
    input  wire logic        short_circuit,
    input  wire logic        bootstrap_low,
    output logic             adapter_gate_drive,
    output logic             battery_gate_drive,
    output logic             charge_enable,
    output logic      [6:0]  charge_current_target,
    output logic             current_monitor_sel,
    output logic      [1:0]  depletion_sel,
    output logic             bootstrap_refresh
);

    cpps_state_t q_ff;
    cpps_state_t nxt_q;

    logic        setup;
    logic        wr_en;
    logic        addr_hit;
    logic [31:0] rd_word;
    logic        calibration_discharge_mode;
    logic        adp_off;
    logic        bat_cond;
    logic        lim_ok;
    logic [1:0]  wd_sel;
    logic [27:0] wd_lim;
    logic [27:0] dly_lim;
    logic [6:0]  cc_units;

    // ===========================================================
    // combinational helpers
    always_comb begin
        setup    = psel & ~penable;
        wr_en    = psel & penable & pwrite & q_ff.pready;
        addr_hit = (paddr == ADDR_OPTION) || (paddr == ADDR_CHG_VOLT) || (paddr == ADDR_CHG_CURR)
                   || (paddr == ADDR_IN_CURR) || (paddr == ADDR_STATUS);
        case (paddr)
            ADDR_OPTION:   rd_word = {16'h0000, q_ff.opt};
            ADDR_CHG_VOLT: rd_word = {16'h0000, q_ff.cv};
            ADDR_CHG_CURR: rd_word = {16'h0000, q_ff.cc};
            ADDR_IN_CURR:  rd_word = {16'h0000, q_ff.ic};
            ADDR_STATUS:   rd_word = {13'h0000, q_ff.target, q_ff.fail_cnt, 3'(q_ff.st), q_ff.wd_exp,
                                      q_ff.chg_en, q_ff.bat_drv, q_ff.adp_drv, q_ff.long_ok, q_ff.current_limit_input_ok};
            default:       rd_word = 32'h0000_0000;
        endcase
        calibration_discharge_mode    = q_ff.opt[OPT_DISCHARGE];
        adp_off  = !adapter_ok || (calibration_discharge_mode && !below_depletion);
        bat_cond = vcc_above_undervoltage_lockout && battery_sense_above_undervoltage_lockout && adapter_sense_negative_ok;
        lim_ok   = (q_ff.cv[CV_HI:CV_LO] != 11'h000) && (q_ff.cc[CC_HI:CC_LO] != 7'h00)
                   && (q_ff.ic[IC_HI:IC_LO] != 6'h00);
        cc_units = q_ff.cc[CC_HI:CC_LO];
        // code-to-period mapping kept as a parameter since the field code is not fixed
        wd_sel   = P_WD_MAP[2 * q_ff.opt[OPT_WD_LO +: 2] +: 2];
        case (wd_sel)
            2'h1:    wd_lim = P_WD_44;
            2'h2:    wd_lim = P_WD_88;
            2'h3:    wd_lim = P_WD_175;
            default: wd_lim = 28'h000_0000;
        endcase
        // long delay only after the adapter path has been dropped once
        dly_lim  = (q_ff.long_ok && q_ff.opt[OPT_LONG_DLY]) ? P_DLY_LONG : P_DLY_SHORT;
    end

    // ===========================================================
    // next-state logic
    always_comb begin
        nxt_q      = q_ff;
        nxt_q.tick = 1'b0;

        // free-running time base, every delay counts these ticks
        if (q_ff.tick_cnt == TICK_CYC - 8'h01) begin
            nxt_q.tick_cnt = 8'h00;
            nxt_q.tick     = 1'b1;
        end else begin
            nxt_q.tick_cnt = q_ff.tick_cnt + 8'h01;
        end

        // apb: one wait-free access phase, data captured at setup
        nxt_q.pready  = setup;
        nxt_q.pslverr = setup & ~addr_hit;
        if (setup) begin
            nxt_q.prdata = rd_word;
        end
        if (wr_en) begin
            case (paddr)
                ADDR_OPTION:   nxt_q.opt = pwdata[15:0];
                ADDR_CHG_VOLT: nxt_q.cv  = pwdata[15:0];
                ADDR_CHG_CURR: nxt_q.cc  = pwdata[15:0];
                ADDR_IN_CURR:  nxt_q.ic  = pwdata[15:0];
                default:       nxt_q.cv  = q_ff.cv;
            endcase
        end

        // state timer in ticks
        if (q_ff.tick) begin
            nxt_q.tmr = q_ff.tmr + 28'h000_0001;
        end

        // failure window: spaced-out failures never accumulate
        if (q_ff.fail_cnt == 3'h0) begin
            nxt_q.win_cnt = 28'h000_0000;
        end else if (q_ff.win_cnt >= P_FAIL_WIN) begin
            nxt_q.win_cnt  = 28'h000_0000;
            nxt_q.fail_cnt = 3'h0;
        end else if (q_ff.tick) begin
            nxt_q.win_cnt = q_ff.win_cnt + 28'h000_0001;
        end

        // power-path selection
        case (q_ff.st)
            S_BAT: begin
                if (adapter_ok && (!calibration_discharge_mode || below_depletion)) begin
                    if (calibration_discharge_mode) begin
                        nxt_q.opt[OPT_DISCHARGE] = 1'b0;
                        nxt_q.st = S_BRK_A;
                    end else begin
                        nxt_q.st = S_DLY;
                    end
                end
            end
            S_DLY: begin
                if (adp_off) begin
                    nxt_q.st = S_BAT;
                end else if (q_ff.tmr >= dly_lim) begin
                    nxt_q.st = S_BRK_A;
                end
            end
            S_BRK_A: begin
                if (adp_off) begin
                    nxt_q.st = S_BAT;
                end else if (q_ff.tmr >= BBM_TK) begin
                    nxt_q.st = S_ADP_ON;
                end
            end
            S_ADP_ON: begin
                if (adp_off) begin
                    nxt_q.st = S_BRK_B;
                end else if (q_ff.tmr >= P_GATE_CHK) begin
                    if (gate_voltage_ok) begin
                        nxt_q.st = S_ADP;
                    end else begin
                        // a window expiring in this very cycle restarts the count at one
                        nxt_q.fail_cnt = nxt_q.fail_cnt + 3'h1;
                        nxt_q.st = (nxt_q.fail_cnt == FAIL_MAX) ? S_LATCH : S_RETRY;
                    end
                end
            end
            S_ADP: begin
                if (adp_off) begin
                    nxt_q.st = S_BRK_B;
                end
            end
            S_BRK_B: begin
                if (q_ff.tmr >= BBM_TK) begin
                    nxt_q.st = S_BAT;
                end
            end
            S_RETRY: begin
                if (q_ff.tmr >= P_RETRY) begin
                    nxt_q.st = adp_off ? S_BAT : S_BRK_A;
                end
            end
            S_LATCH: begin
                nxt_q.st = S_LATCH;
            end
            default: begin
                nxt_q.st = S_BAT;
            end
        endcase
        if (nxt_q.st != q_ff.st) begin
            nxt_q.tmr = 28'h000_0000;
        end

        // switch drives: disjoint state sets keep the two paths apart
        nxt_q.adp_drv = (nxt_q.st == S_ADP_ON) || (nxt_q.st == S_ADP);
        nxt_q.bat_drv = bat_cond && ((nxt_q.st == S_BAT) || (nxt_q.st == S_DLY)
                        || (nxt_q.st == S_RETRY) || (nxt_q.st == S_LATCH));
        if (q_ff.adp_drv && !nxt_q.adp_drv) begin
            nxt_q.long_ok = 1'b1;
        end

        // watchdog: charge voltage and charge current writes restart it, disabling clears expiry
        if (wr_en && ((paddr == ADDR_CHG_VOLT) || (paddr == ADDR_CHG_CURR))) begin
            nxt_q.wd_cnt = 28'h000_0000;
            nxt_q.wd_exp = 1'b0;
        end else if (wd_sel == 2'h0) begin
            nxt_q.wd_cnt = 28'h000_0000;
            nxt_q.wd_exp = 1'b0;
        end else if (!q_ff.wd_exp) begin
            if (q_ff.wd_cnt >= wd_lim) begin
                nxt_q.wd_exp = 1'b1;
            end else if (q_ff.tick) begin
                nxt_q.wd_cnt = q_ff.wd_cnt + 28'h000_0001;
            end
        end

        // current-limit pin hysteresis between start and stop levels
        if (current_limit_above_start) begin
            nxt_q.current_limit_input_ok = 1'b1;
        end else if (current_limit_below_stop) begin
            nxt_q.current_limit_input_ok = 1'b0;
        end

        // charge qualification
        nxt_q.chg_en = !q_ff.opt[OPT_INHIBIT] && q_ff.current_limit_input_ok && lim_ok && adapter_ok
                       && (nxt_q.st == S_ADP) && gate_voltage_ok && !battery_overvoltage
                       && !thermal_shutdown && !input_overcurrent && !short_circuit
                       && !q_ff.wd_exp;

        // soft start ramps the current target upward
        if (!nxt_q.chg_en) begin
            nxt_q.target = 7'h00;
            nxt_q.ss_cnt = 28'h000_0000;
        end else if (!q_ff.chg_en) begin
            nxt_q.target = SS_START;
            nxt_q.ss_cnt = 28'h000_0000;
        end else if (q_ff.target > cc_units) begin
            nxt_q.target = cc_units;
        end else if (q_ff.target < cc_units && q_ff.tick) begin
            if (q_ff.ss_cnt >= P_SS_STEP - 28'h000_0001) begin
                nxt_q.target = q_ff.target + 7'h01;
                nxt_q.ss_cnt = 28'h000_0000;
            end else begin
                nxt_q.ss_cnt = q_ff.ss_cnt + 28'h000_0001;
            end
        end

        nxt_q.imon_sel = nxt_q.opt[OPT_IMON_SEL];
        nxt_q.dep_sel  = nxt_q.opt[OPT_DEPL_LO +: 2];
        // refresh only while the converter switches; limits duty to about 99.5%
        nxt_q.bst_ref  = bootstrap_low && nxt_q.chg_en;
    end

    // ===========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff     <= '0;
            q_ff.opt <= OPTION_RST;
            q_ff.cv  <= CHG_VOLT_RST;
            q_ff.cc  <= CHG_CURR_RST;
            q_ff.ic  <= IN_CURR_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign prdata                = q_ff.prdata;
    assign pready                = q_ff.pready;
    assign pslverr               = q_ff.pslverr;
    assign adapter_gate_drive    = q_ff.adp_drv;
    assign battery_gate_drive    = q_ff.bat_drv;
    assign charge_enable         = q_ff.chg_en;
    assign charge_current_target = q_ff.target;
    assign current_monitor_sel   = q_ff.imon_sel;
    assign depletion_sel         = q_ff.dep_sel;
    assign bootstrap_refresh     = q_ff.bst_ref;

    // ===========================================================
    // assertions
    a_bbm_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        !(adapter_gate_drive && battery_gate_drive))
        else $error("adapter and battery switches on together");

    a_chg_needs_adp: assert property (@(posedge pclk) disable iff (!presetn)
        charge_enable |-> adapter_gate_drive)
        else $error("charging with adapter path off");

    a_bat_conditions: assert property (@(posedge pclk) disable iff (!presetn)
        battery_gate_drive |-> $past(vcc_above_undervoltage_lockout && battery_sense_above_undervoltage_lockout && adapter_sense_negative_ok))
        else $error("battery switch on without healthy conditions");

    a_calibration_discharge_mode_exit: assert property (@(posedge pclk) disable iff (!presetn)
        (q_ff.st == S_BAT && calibration_discharge_mode && adapter_ok && below_depletion) |=> !q_ff.opt[OPT_DISCHARGE])
        else $error("discharge mode bit not cleared on depletion");

    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (q_ff.st == S_LATCH) |=> (q_ff.st == S_LATCH) && !adapter_gate_drive)
        else $error("latched state left");

    a_inhibit_stop: assert property (@(posedge pclk) disable iff (!presetn)
        q_ff.opt[OPT_INHIBIT] |=> !charge_enable)
        else $error("charging while inhibited");

    a_ss_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(charge_enable) |-> charge_current_target == SS_START)
        else $error("soft start did not begin at start value");

    a_adp_off: assert property (@(posedge pclk) disable iff (!presetn)
        !adapter_ok |=> !adapter_gate_drive)
        else $error("adapter path on with adapter not ok");

    a_wd_stop: assert property (@(posedge pclk) disable iff (!presetn)
        q_ff.wd_exp |=> !charge_enable)
        else $error("charging after watchdog expiry");

    // a landed charge voltage or charge current write clears any pending watchdog expiry
    a_wd_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && (paddr == ADDR_CHG_VOLT || paddr == ADDR_CHG_CURR)) |=> !q_ff.wd_exp)
        else $error("watchdog not restarted by setting write");

    // monitor source follows the option bit as soon as the write lands
    a_imon_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && paddr == ADDR_OPTION)
        |=> (current_monitor_sel == $past(pwdata[OPT_IMON_SEL])))
        else $error("monitor source does not follow option write");

    // depletion threshold code follows the option field as soon as the write lands
    a_dep_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && paddr == ADDR_OPTION)
        |=> (depletion_sel == $past(pwdata[OPT_DEPL_LO +: 2])))
        else $error("depletion select does not follow option write");

    // refresh pulses only follow a low bootstrap voltage while switching
    a_bst_refresh: assert property (@(posedge pclk) disable iff (!presetn)
        bootstrap_refresh |-> $past(bootstrap_low) && charge_enable)
        else $error("refresh without low bootstrap voltage");

    // a failed gate check drops the adapter path at the next edge
    a_gate_fail: assert property (@(posedge pclk) disable iff (!presetn)
        (q_ff.st == S_ADP_ON && q_ff.tmr >= P_GATE_CHK && !gate_voltage_ok) |=> !adapter_gate_drive)
        else $error("adapter path kept on after failed gate check");

    // any converter fault drops charging at the next edge
    a_fault_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (battery_overvoltage || thermal_shutdown || input_overcurrent || short_circuit) |=> !charge_enable)
        else $error("charging continued through a fault");

    // no changeover starts while the adapter is not usable
    a_swap_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (q_ff.st == S_BAT && !(adapter_ok && (!calibration_discharge_mode || below_depletion))) |=> (q_ff.st == S_BAT))
        else $error("changeover started without a usable adapter");

endmodule : cpps_top

`default_nettype wire

// ### tb/cpps_host.sv
// apb host model standing in for the power-management controller
// assumes the sequencer answers each access with pready
`timescale 1ns/10ps
`default_nettype none
module cpps_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic        pready
);
    // ==========================================
    // one transfer: setup, access held until pready is sampled high
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // released lines carry inverted values so stale data never looks valid
        {psel, penable, pwrite, paddr, pwdata} <= {2'b00, ~w, ~a, ~d};
    endtask : xfer
endmodule : cpps_host
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the power-path sequencer
// assumes cpps_host drives apb; short delay, gate check, retry, 44 s watchdog and soft-start step shrunk by parameters
`timescale 1ns/10ps
`default_nettype none
module tb_top import cpps_pkg::*; ;
    localparam int TK = 200;
    localparam int GC = 3;
    logic        pclk = 1'b0;
    logic        presetn, aok, gok, dep, bst, psel, penable, pwrite, pready, pslverr, adg, bgd, ce, ims, brf;
    logic [2:0]  hl;
    logic [4:0]  flt;
    logic [7:0]  paddr;
    logic [31:0] prdata, pwdata;
    logic [6:0]  tgt;
    logic [1:0]  dsl;
    logic [15:0] o;
    logic [31:0] q[$];
    int          bad_count, n_compared, n, i;
    wire  [2:0]  ob = {ce, bgd, adg};
    // ==========================================
    cpps_top #(.P_DLY_SHORT(28'h4), .P_GATE_CHK(28'h3), .P_RETRY(28'h5), .P_WD_44(28'h14),
        .P_SS_STEP(28'h2)) cpps_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .adapter_ok(aok), .vcc_above_undervoltage_lockout(hl[2]), .battery_sense_above_undervoltage_lockout(hl[1]),
        .adapter_sense_negative_ok(hl[0]), .gate_voltage_ok(gok), .below_depletion(dep),
        .current_limit_above_start(~flt[0]), .current_limit_below_stop(flt[0]), .battery_overvoltage(flt[1]),
        .thermal_shutdown(flt[2]), .input_overcurrent(flt[3]), .short_circuit(flt[4]), .bootstrap_low(bst),
        .adapter_gate_drive(adg), .battery_gate_drive(bgd), .charge_enable(ce), .charge_current_target(tgt),
        .current_monitor_sel(ims), .depletion_sel(dsl), .bootstrap_refresh(brf));
    cpps_host cpps_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);
    always #2.5 pclk = ~pclk;
    // ==========================================
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        cpps_host_inst.xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cpps_host_inst.xfer(1'b1, a, {16'h0, d});
    endtask : wr
    // bounded wait for one of ce, bgd, adg; n keeps the cycles it took
    task automatic wt(input int k, input logic v, input int lim);
        for (n = 0; ob[k] !== v && n < lim; n++) @(posedge pclk);
        chk(32'(ob[k]), 32'(v));
    endtask : wt
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // read data checked against the oldest note; both switches on is never legal
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0) chk(prdata, q.pop_front());
        if (psel && penable && pready) chk(32'(pslverr), 32'(paddr > ADDR_STATUS));
        if (adg && bgd) chk(32'h1, 32'h0);
    end
    // ==========================================
    initial begin
        void'($urandom(32'h2342fec1));
        {presetn, aok, dep, bst, flt} = '0;
        {hl, gok} = 4'hf;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(ob), 32'h2);
        hl <= 3'h7 ^ 3'(1 << ($urandom % 3));
        repeat (3) @(posedge pclk);
        chk(32'(ob), 32'h0);
        hl <= 3'h7;
        rd(ADDR_OPTION, 32'h6000);
        rd(8'h40, 32'h0);
        aok <= 1'b1;
        wt(0, 1'b1, 12 * TK);
        chk(32'(n >= 4 * TK), 32'h1);
        wr(ADDR_CHG_VOLT, 16'h1000);
        wr(ADDR_CHG_CURR, 16'h0100);
        wt(2, 1'b1, 4 * TK);
        chk(32'(tgt), 32'h2);
        repeat (6 * TK) @(posedge pclk);
        chk(32'(tgt), 32'h4);
        bst <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(brf), 32'h1);
        bst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            flt <= 5'(1 << i);
            wt(2, 1'b0, 4);
            flt <= 5'h0;
            wt(2, 1'b1, 4);
        end
        wr(ADDR_OPTION, 16'h6001);
        wt(2, 1'b0, 4);
        $display("test power path and charge done");
        for (i = 0; i < 4; i++) begin
            o = 16'h6000 | 16'(i << 11) | 16'($urandom & 32'h20);
            wr(ADDR_OPTION, o);
            repeat (2) @(posedge pclk);
            chk(32'({dsl, ims}), 32'({i[1:0], o[5]}));
            rd(ADDR_OPTION, 32'(o));
        end
        wr(ADDR_OPTION, 16'h2000);
        wr(ADDR_CHG_CURR, 16'h0100);
        wt(2, 1'b0, 30 * TK);
        chk(32'(n > 18 * TK && n < 22 * TK), 32'h1);
        rd(ADDR_CHG_CURR, 32'h0100);
        wr(ADDR_CHG_CURR, 16'h0100);
        wt(2, 1'b1, 8);
        wt(2, 1'b0, 30 * TK);
        wr(ADDR_OPTION, 16'h0000);
        wt(2, 1'b1, 8);
        wr(ADDR_OPTION, 16'h0040);
        wt(1, 1'b1, 3 * TK);
        chk(32'(ob), 32'h2);
        dep <= 1'b1;
        wt(0, 1'b1, 3 * TK);
        rd(ADDR_OPTION, 32'h0);
        aok <= 1'b0;
        wt(1, 1'b1, 3 * TK);
        chk(32'(ob), 32'h2);
        {dep, gok, aok} <= 3'b001;
        $display("test watchdog and discharge done");
        wt(0, 1'b1, 12 * TK);
        wt(0, 1'b0, (GC + 2) * TK);
        chk(32'(n > (GC - 1) * TK), 32'h1);
        repeat (90 * TK) @(posedge pclk);
        n = 0;
        for (i = 0; i < 12 * TK; i++) @(posedge pclk) n += adg;
        chk(n, 0);
        {presetn, gok} <= 2'b01;
        @(posedge pclk) presetn <= 1'b1;
        wt(0, 1'b1, 12 * TK);
        $display("test latch-off done");
        conclude();
    end
    // about 40000 cycles of tests; twice that means a hang
    initial begin
        #(80000 * 5);
        bad_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
